/* hdl/dcs_pkg.sv */
/*
  shared constants, types and helpers for the converter configuration and
  status register block.
  assumes one 10 MHz system clock and a slow serial link sampled by it.
*/
package dcs_pkg;

  // ************************************************************
  // register map
  // ************************************************************
  localparam logic [6:0]  ADDR_ALARM_FLAGS   = 7'h02;
  localparam logic [6:0]  ADDR_SERIAL_CFG    = 7'h03;
  localparam logic [6:0]  ADDR_GENERAL_CFG   = 7'h04;
  localparam logic [6:0]  ADDR_CONV_PD       = 7'h09;
  localparam logic [6:0]  ADDR_RANGE         = 7'h0a;
  localparam logic [6:0]  ADDR_TRIGGER       = 7'h0e;

  localparam logic [15:0] RST_ALARM_FLAGS    = 16'h0000;
  localparam logic [15:0] RST_SERIAL_CFG     = 16'h0aa4;
  localparam logic [15:0] RST_GENERAL_CFG    = 16'h0000;
  localparam logic [15:0] RST_CONV_PD        = 16'hffff;
  localparam logic [15:0] RST_RANGE          = 16'h0000;

  localparam logic [15:0] SCFG_WR_MASK       = 16'h0e36;
  localparam logic [15:0] GCFG_WR_MASK       = 16'h4000;
  localparam logic [15:0] PD_WR_MASK         = 16'h0001;
  localparam logic [15:0] RANGE_WR_MASK      = 16'h000f;

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int unsigned BIT_OVERHEAT_ROUTE = 11;
  localparam int unsigned BIT_BUSY_ROUTE     = 10;
  localparam int unsigned BIT_CHECK_ROUTE    = 9;
  localparam int unsigned BIT_DEVICE_SLEEP   = 5;
  localparam int unsigned BIT_FRAME_CHECK    = 4;
  localparam int unsigned BIT_DATA_OUT_EN    = 2;
  localparam int unsigned BIT_DATA_OUT_FALL  = 1;
  localparam int unsigned BIT_REF_OFF        = 14;
  localparam int unsigned BIT_CONV_SLEEP     = 0;
  localparam int unsigned BIT_ALARM_CLEAR    = 8;
  localparam int unsigned BIT_ST_CHECK       = 2;
  localparam int unsigned BIT_ST_BUSY        = 1;
  localparam int unsigned BIT_ST_OVERHEAT    = 0;

  // ************************************************************
  // framing
  // ************************************************************
  localparam logic [5:0]  FRAME_BITS         = 6'h18;
  localparam logic [5:0]  FRAME_BITS_CHECK   = 6'h20;
  localparam logic [5:0]  CMD_LAST_BIT       = 6'h07;
  localparam logic [7:0]  CHECK_POLY         = 8'h07;
  localparam logic [7:0]  CHECK_INIT         = 8'h00;

  // ************************************************************
  // types
  // ************************************************************
  typedef enum logic [1:0]
  {
    ST_IDLE   = 2'b00,
    ST_SHIFT  = 2'b01,
    ST_COMMIT = 2'b10
  } dcs_state_t;

  typedef struct packed
  {
    logic sclk_rise;
    logic sclk_fall;
    logic frame_active;
    logic frame_end;
    logic sdi;
  } dcs_link_t;

  typedef struct packed
  {
    logic       valid;
    logic       bipolar;
    logic [5:0] span_volts;
  } dcs_range_t;

  // ************************************************************
  // helpers
  // ************************************************************
  function automatic logic [15:0] dcs_merge(input logic [15:0] old_v,
                                            input logic [15:0] new_v,
                                            input logic [15:0] mask);
    dcs_merge = (old_v & ~mask) | (new_v & mask);
  endfunction

  function automatic dcs_range_t dcs_decode_range(input logic [3:0] code);
    dcs_range_t r;
    r = '{valid: 1'b1, bipolar: code[2], span_volts: 6'h00};
    case (code)
      4'h0:    r.span_volts = 6'h05;
      4'h8:    r.span_volts = 6'h06;
      4'h1:    r.span_volts = 6'h0a;
      4'h9:    r.span_volts = 6'h0c;
      4'h2:    r.span_volts = 6'h14;
      4'ha:    r.span_volts = 6'h18;
      4'h3:    r.span_volts = 6'h28;
      4'h5:    r.span_volts = 6'h05;
      4'hd:    r.span_volts = 6'h06;
      4'h6:    r.span_volts = 6'h0a;
      4'he:    r.span_volts = 6'h0c;
      4'h7:    r.span_volts = 6'h14;
      default: r = '{valid: 1'b0, bipolar: 1'b0, span_volts: 6'h00};
    endcase
    dcs_decode_range = r;
  endfunction

endpackage

/* hdl/dcs_link_sync.sv */
/*
  brings the serial link pins into the system clock domain and finds the
  link clock edges and the frame boundaries.
  assumes the link clock is at least eight system clocks per period.
*/
`timescale 1ns/1ps
module dcs_link_sync
  import dcs_pkg::*;
(
  input  wire logic              i_clk,
  input  wire logic              i_reset_n,
  input  wire logic              i_sclk,
  input  wire logic              i_cs_n,
  input  wire logic              i_sdi,
  output dcs_pkg::dcs_link_t     o_link
);

  logic [2:0] sclk_r;
  logic [2:0] cs_n_r;
  logic [1:0] sdi_r;

  // ************************************************************
  // two-flop synchronisers; link clock and select add one history stage
  // ************************************************************
  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n)
    begin
      sclk_r <= 3'h0;
      cs_n_r <= 3'h7;
      sdi_r  <= 2'h0;
    end
    else
    begin
      sclk_r <= {sclk_r[1:0], i_sclk};
      cs_n_r <= {cs_n_r[1:0], i_cs_n};
      sdi_r  <= {sdi_r[0], i_sdi};
    end
  end

  // edges only look at the second and third stages
  always_comb
  begin
    o_link.sclk_rise    = sclk_r[1] & ~sclk_r[2];
    o_link.sclk_fall    = ~sclk_r[1] & sclk_r[2];
    o_link.frame_active = ~cs_n_r[1];
    o_link.frame_end    = cs_n_r[1] & ~cs_n_r[2];
    o_link.sdi          = sdi_r[1];
  end

endmodule

/* hdl/dcs_crc8.sv */
/*
  bit-serial frame check accumulator, msb first.
  assumes the caller clears it at frame start and feeds only payload bits.
*/
`timescale 1ns/1ps
module dcs_crc8
  import dcs_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_reset_n,
  input  wire logic       i_clear,
  input  wire logic       i_bit_valid,
  input  wire logic       i_bit,
  output logic [7:0]      o_crc
);

  logic fb;

  assign fb = o_crc[7] ^ i_bit;

  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n || i_clear)
      o_crc <= CHECK_INIT;
    else if (i_bit_valid)
      o_crc <= {o_crc[6:0], 1'b0} ^ (fb ? CHECK_POLY : 8'h00);
  end

endmodule

/* hdl/dcs_regs.sv */
/*
  configuration and status registers of a serially programmed converter:
  alarm flags, fault routing, data-out options, power-down and range.
  assumes a host drives link clock, select and data in; alarm inputs come
  from the analog side (overheat, asynchronous) and the update engine
  (busy, same clock).

*/
`timescale 1ns/1ps
module dcs_regs
  import dcs_pkg::*;
(
  input  wire logic              i_clk,
  input  wire logic              i_reset_n,
  input  wire logic              i_sclk,
  input  wire logic              i_cs_n,
  input  wire logic              i_sdi,
  input  wire logic              i_overheat,
  input  wire logic              i_update_busy,
  output logic                   o_sdo,
  output logic                   o_sdo_oe,
  output logic                   o_fault,
  output logic                   o_device_sleep,
  output logic                   o_reference_off,
  output logic                   o_converter_sleep,
  output logic                   o_frame_check_on,
  output logic [3:0]             o_range_code,
  output dcs_pkg::dcs_range_t    o_range
);

  dcs_link_t   link;
  dcs_state_t  state_r;
  logic [5:0]  bit_cnt_r;
  logic [31:0] shift_r;
  logic [7:0]  crc;
  logic [15:0] serial_cfg_r;
  logic [15:0] general_cfg_r;
  logic [15:0] conv_pd_r;
  logic [15:0] range_r;
  logic [15:0] out_sr_r;
  logic [15:0] rd_word;
  logic [15:0] alarm_word;
  logic [1:0]  overheat_r;
  logic        busy_r;
  logic        overheat_lat_r;
  logic        check_lat_r;
  logic        rd_phase_r;
  logic        check_on;
  logic        len_ok;
  logic [23:0] word;
  logic        check_fail;
  logic        wr_commit;
  logic        alarm_clear;
  logic [7:0]  cmd_byte;
  logic        rd_load;
  logic        sdo_step;

  // ************************************************************
  // link front end and check accumulator
  // ************************************************************
  dcs_link_sync u_sync
  (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .i_sclk    (i_sclk),
    .i_cs_n    (i_cs_n),
    .i_sdi     (i_sdi),
    .o_link    (link)
  );

  dcs_crc8 u_crc
  (
    .i_clk       (i_clk),
    .i_reset_n   (i_reset_n),
    .i_clear     (state_r == ST_IDLE),
    .i_bit_valid (state_r == ST_SHIFT && link.sclk_fall && bit_cnt_r < FRAME_BITS),
    .i_bit       (link.sdi),
    .o_crc       (crc)
  );

  // ************************************************************
  // frame sequencing
  // ************************************************************
  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n)
      state_r <= ST_IDLE;
    else
      case (state_r)
        ST_IDLE:   if (link.frame_active) state_r <= ST_SHIFT;
        ST_SHIFT:  if (link.frame_end) state_r <= ST_COMMIT;
        ST_COMMIT: state_r <= ST_IDLE;
        default:   state_r <= ST_IDLE;
      endcase
  end

  // data in is taken on falling link clock edges; count saturates
  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n || state_r == ST_IDLE)
    begin
      bit_cnt_r <= 6'h00;
      shift_r   <= 32'h0;
    end
    else if (state_r == ST_SHIFT && link.sclk_fall)
    begin
      shift_r <= {shift_r[30:0], link.sdi};
      if (bit_cnt_r != 6'h3f)
        bit_cnt_r <= bit_cnt_r + 6'h01;
    end
  end

  // frame is judged at select release; a wrong length is dropped silently
  always_comb
  begin
    check_on    = serial_cfg_r[BIT_FRAME_CHECK];
    len_ok      = bit_cnt_r == (check_on ? FRAME_BITS_CHECK : FRAME_BITS);
    word        = check_on ? shift_r[31:8] : shift_r[23:0];
    check_fail  = state_r == ST_COMMIT && check_on && len_ok && shift_r[7:0] != crc;
    wr_commit   = state_r == ST_COMMIT && len_ok && !check_fail && !word[23];
    alarm_clear = wr_commit && word[22:16] == ADDR_TRIGGER && word[BIT_ALARM_CLEAR];
    cmd_byte    = {shift_r[6:0], link.sdi};
    rd_load     = state_r == ST_SHIFT && link.sclk_fall && bit_cnt_r == CMD_LAST_BIT
                  && cmd_byte[7];
  end

  // ************************************************************
  // writable registers; masks keep reserved and fixed bits
  // ************************************************************
  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n)
      serial_cfg_r <= RST_SERIAL_CFG;
    else if (wr_commit && word[22:16] == ADDR_SERIAL_CFG)
      serial_cfg_r <= dcs_merge(serial_cfg_r, word[15:0], SCFG_WR_MASK);
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n)
      general_cfg_r <= RST_GENERAL_CFG;
    else if (wr_commit && word[22:16] == ADDR_GENERAL_CFG)
      general_cfg_r <= dcs_merge(general_cfg_r, word[15:0], GCFG_WR_MASK);
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n)
      conv_pd_r <= RST_CONV_PD;
    else if (wr_commit && word[22:16] == ADDR_CONV_PD)
      conv_pd_r <= dcs_merge(conv_pd_r, word[15:0], PD_WR_MASK);
  end

  // any code is stored; invalid ones show up as o_range.valid low
  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n)
      range_r <= RST_RANGE;
    else if (wr_commit && word[22:16] == ADDR_RANGE)
      range_r <= dcs_merge(range_r, word[15:0], RANGE_WR_MASK);
  end

  // ************************************************************
  // alarms: set wins over a clear in the same cycle
  // ************************************************************
  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n)
    begin
      overheat_r <= 2'h0;
      busy_r     <= 1'b0;
    end
    else
    begin
      overheat_r <= {overheat_r[0], i_overheat};
      busy_r     <= i_update_busy;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n)
      overheat_lat_r <= 1'b0;
    else if (overheat_r[1])
      overheat_lat_r <= 1'b1;
    else if (alarm_clear)
      overheat_lat_r <= 1'b0;
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n)
      check_lat_r <= 1'b0;
    else if (check_fail)
      check_lat_r <= 1'b1;
    else if (alarm_clear)
      check_lat_r <= 1'b0;
  end

  // busy is live and never latched, so the clear does not touch it
  always_comb
  begin
    alarm_word                  = RST_ALARM_FLAGS;
    alarm_word[BIT_ST_CHECK]    = check_lat_r;
    alarm_word[BIT_ST_BUSY]     = busy_r;
    alarm_word[BIT_ST_OVERHEAT] = overheat_lat_r;
  end

  // ************************************************************
  // readback; unmapped and write-only addresses read zero
  // ************************************************************
  always_comb
  begin
    case (cmd_byte[6:0])
      ADDR_ALARM_FLAGS: rd_word = alarm_word;
      ADDR_SERIAL_CFG:  rd_word = serial_cfg_r;
      ADDR_GENERAL_CFG: rd_word = general_cfg_r;
      ADDR_CONV_PD:     rd_word = conv_pd_r;
      ADDR_RANGE:       rd_word = range_r;
      default:          rd_word = 16'h0000;
    endcase
  end

  assign sdo_step = serial_cfg_r[BIT_DATA_OUT_FALL] ? link.sclk_fall : link.sclk_rise;

  // falling mode presents the first bit at once, half a clock earlier
  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n || state_r != ST_SHIFT)
    begin
      rd_phase_r <= 1'b0;
      out_sr_r   <= 16'h0000;
      o_sdo      <= 1'b0;
    end
    else if (rd_load)
    begin
      rd_phase_r <= 1'b1;
      if (serial_cfg_r[BIT_DATA_OUT_FALL])
      begin
        o_sdo    <= rd_word[15];
        out_sr_r <= {rd_word[14:0], 1'b0};
      end
      else
        out_sr_r <= rd_word;
    end
    else if (rd_phase_r && sdo_step)
    begin
      o_sdo    <= out_sr_r[15];
      out_sr_r <= {out_sr_r[14:0], 1'b0};
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n)
      o_sdo_oe <= 1'b0;
    else
      o_sdo_oe <= serial_cfg_r[BIT_DATA_OUT_EN] && link.frame_active;
  end

  // ************************************************************
  // pins toward the analog side
  // ************************************************************
  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n)
      o_fault <= 1'b0;
    else
      o_fault <= (overheat_lat_r & serial_cfg_r[BIT_OVERHEAT_ROUTE])
               | (busy_r & serial_cfg_r[BIT_BUSY_ROUTE])
               | (check_lat_r & serial_cfg_r[BIT_CHECK_ROUTE]);
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n)
    begin
      o_device_sleep    <= RST_SERIAL_CFG[BIT_DEVICE_SLEEP];
      o_reference_off   <= RST_GENERAL_CFG[BIT_REF_OFF];
      o_converter_sleep <= RST_CONV_PD[BIT_CONV_SLEEP];
      o_frame_check_on  <= RST_SERIAL_CFG[BIT_FRAME_CHECK];
      o_range_code      <= RST_RANGE[3:0];
      o_range           <= dcs_decode_range(RST_RANGE[3:0]);
    end
    else
    begin
      o_device_sleep    <= serial_cfg_r[BIT_DEVICE_SLEEP];
      o_reference_off   <= general_cfg_r[BIT_REF_OFF];
      o_converter_sleep <= conv_pd_r[BIT_CONV_SLEEP] | overheat_lat_r;
      o_frame_check_on  <= check_on;
      o_range_code      <= range_r[3:0];
      o_range           <= dcs_decode_range(range_r[3:0]);
    end
  end

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);

  // other routed alarms may hold the pin high as well, so only a missing route fails
  AST_CHECK_FLAG: assert property (check_fail |=> check_lat_r
                    ##1 (o_fault || !serial_cfg_r[9]))
    else $error("check error not flagged or routed");
  AST_BUSY_READ: assert property (alarm_word[1] == $past(i_update_busy))
    else $error("busy flag does not follow converter");
  AST_OVH_SLEEP: assert property (overheat_r[1] |=> ##1 o_converter_sleep)
    else $error("overheat did not force converter sleep");
  AST_OVH_ROUTE: assert property (overheat_lat_r && serial_cfg_r[11] |=> o_fault)
    else $error("routed overheat missing on fault");
  AST_FAULT_OR: assert property (o_fault == $past((busy_r & serial_cfg_r[10])
                    | (overheat_lat_r & serial_cfg_r[11]) | (check_lat_r & serial_cfg_r[9])))
    else $error("fault pin not the gated or of alarms");
  AST_SLEEP: assert property (o_device_sleep == $past(serial_cfg_r[5]))
    else $error("device sleep does not track config");
  AST_NO_CHECK: assert property (state_r == ST_COMMIT && !serial_cfg_r[4] |-> !check_fail)
    else $error("frame check raised while disabled");
  AST_OE: assert property (!serial_cfg_r[2] |=> !o_sdo_oe)
    else $error("data out driven while disabled");
  AST_SDO_EDGE: assert property (rd_phase_r && !sdo_step && state_r == ST_SHIFT
                    |=> $stable(o_sdo) || state_r != ST_SHIFT)
    else $error("data out changed off its edge");
  AST_RESET_VAL: assert property ($rose(i_reset_n) |-> serial_cfg_r == 16'h0aa4
                    && conv_pd_r == 16'hffff && alarm_word == 16'h0000)
    else $error("reset values wrong");
  AST_REF: assert property (o_reference_off == $past(general_cfg_r[14]))
    else $error("reference control does not track config");
  AST_CLEAR: assert property (alarm_clear && !check_fail |=> !check_lat_r)
    else $error("alarm clear did not clear check flag");

  COV_CHECK_FAIL: cover property (check_fail);
  COV_READ_FRAME: cover property (rd_load ##[1:400] link.frame_end);
  COV_CFG_WRITE:  cover property (wr_commit && word[22:16] == ADDR_SERIAL_CFG);
  COV_FAULT:      cover property ($rose(o_fault));

endmodule

/* tb/dcs_host_model.sv */
/*
  host side of the serial link: frames register reads and writes, adds the
  check byte when enabled, and shifts read data back in.
  assumes a 10 MHz clock; link clock is 800 ns and idles low between frames.
*/
`timescale 1ns/1ps
module dcs_host_model
(
  input  wire logic i_clk,
  input  wire logic i_sdo,
  input  wire logic i_sdo_oe,
  output logic      o_sclk,
  output logic      o_cs_n,
  output logic      o_sdi
);
  logic crc_on;
  logic oe_seen;

  initial
  begin
    crc_on  = 1'b0;
    oe_seen = 1'b0;
    o_sclk  = 1'b0;
    o_cs_n  = 1'b1;
    o_sdi   = 1'b0;
  end

  // ************************************************************
  // frame check byte, msb first over the 24 frame bits
  // ************************************************************
  function automatic logic [7:0] crc8(input logic [23:0] d);
    logic [7:0] c;
    logic       fb;
    c = 8'h00;
    for (int i = 23; i >= 0; i--)
    begin
      fb = c[7] ^ d[i];
      c  = {c[6:0], 1'b0} ^ (fb ? 8'h07 : 8'h00);
    end
    return c;
  endfunction

  // ************************************************************
  // one framed access; bad flips bit 0 of the check byte on purpose
  // ************************************************************
  task automatic xfer(input logic rw, input logic [6:0] addr, input logic [15:0] data,
                      input logic bad, output logic [15:0] rd);
    logic [31:0] fr;
    int          nb;
    fr      = {rw, addr, data, 8'h00};
    fr[7:0] = crc8(fr[31:8]) ^ {7'h00, bad};
    nb      = crc_on ? 32 : 24;
    rd      = 16'h0000;
    oe_seen = 1'b0;
    @(posedge i_clk);
    o_cs_n <= 1'b0;
    repeat (4) @(posedge i_clk);
    for (int i = 0; i < nb; i++)
    begin
      o_sdi  <= fr[31 - i];
      o_sclk <= 1'b1;
      repeat (4) @(posedge i_clk);
      o_sclk <= 1'b0;
      @(posedge i_clk);
      // one clock after the fall lies clear of both update edges
      // an undriven line reads as the complement, so stale data never passes
      if (i >= 8 && i < 24)
        rd = {rd[14:0], i_sdo_oe ? i_sdo : ~i_sdo};
      oe_seen = oe_seen | i_sdo_oe;
      repeat (3) @(posedge i_clk);
    end
    o_cs_n <= 1'b1;
    // released data line must not keep looking valid
    o_sdi  <= ~o_sdi;
    repeat (10) @(posedge i_clk);
  endtask
endmodule

/* tb/dcs_regs_tb_top.sv */
/*
  self-checking bench for the configuration and status registers.
  assumes the host model for link traffic; alarm inputs driven here.
*/
`timescale 1ns/1ps
module dcs_regs_tb_top;
  import dcs_pkg::*;

  logic           clk;
  logic           reset_n;
  logic           overheat;
  logic           busy;
  logic           sclk;
  logic           cs_n;
  logic           sdi;
  logic           sdo;
  logic           sdo_oe;
  logic           fault;
  logic           dev_sleep;
  logic           ref_off;
  logic           conv_sleep;
  logic           chk_on;
  logic [3:0]     rcode;
  dcs_range_t     range;
  int             n_errors;
  int             num_checks;

  dcs_regs i_dcs_regs (.i_clk(clk), .i_reset_n(reset_n), .i_sclk(sclk), .i_cs_n(cs_n),
    .i_sdi(sdi), .i_overheat(overheat), .i_update_busy(busy), .o_sdo(sdo),
    .o_sdo_oe(sdo_oe), .o_fault(fault), .o_device_sleep(dev_sleep),
    .o_reference_off(ref_off), .o_converter_sleep(conv_sleep),
    .o_frame_check_on(chk_on), .o_range_code(rcode), .o_range(range));

  dcs_host_model i_dcs_host_model (.i_clk(clk), .i_sdo(sdo), .i_sdo_oe(sdo_oe),
    .o_sclk(sclk), .o_cs_n(cs_n), .o_sdi(sdi));

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // ************************************************************
  // shared tasks
  // ************************************************************
  task automatic close_out();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk16(input logic [15:0] got, input logic [15:0] exp, input string what);
    num_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic cycles(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic wr(input logic [6:0] a, input logic [15:0] d, input logic bad);
    logic [15:0] rd;
    i_dcs_host_model.xfer(1'b0, a, d, bad, rd);
  endtask

  task automatic rd_chk(input logic [6:0] a, input logic [15:0] exp);
    logic [15:0] rd;
    i_dcs_host_model.xfer(1'b1, a, 16'h0000, 1'b0, rd);
    chk16(rd, exp, "readback");
  endtask

  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_reset();
    chk16({15'h0, dev_sleep}, 16'h0001, "sleep");
    chk16({15'h0, conv_sleep}, 16'h0001, "conv");
    chk16({15'h0, fault}, 16'h0000, "fault");
    rd_chk(7'h02, 16'h0000);
    chk16({15'h0, i_dcs_host_model.oe_seen}, 16'h0001, "oe");
    rd_chk(7'h03, 16'h0aa4);
    rd_chk(7'h09, 16'hffff);
    rd_chk(7'h0a, 16'h0000);
    rd_chk(7'h05, 16'h0000);
  endtask

  task automatic t_general();
    wr(7'h04, 16'hffff, 1'b0);
    chk16({15'h0, ref_off}, 16'h0001, "ref");
    rd_chk(7'h04, 16'h4000);
    wr(7'h04, 16'h0000, 1'b0);
    chk16({15'h0, ref_off}, 16'h0000, "ref");
    wr(7'h02, 16'hffff, 1'b0);
    rd_chk(7'h02, 16'h0000);
  endtask

  task automatic t_serial();
    wr(7'h03, 16'h0e26, 1'b0);
    rd_chk(7'h03, 16'h0ea6);
    busy <= 1'b1;
    cycles(4);
    chk16({15'h0, fault}, 16'h0001, "busy");
    rd_chk(7'h02, 16'h0002);
    busy <= 1'b0;
    cycles(4);
    chk16({15'h0, fault}, 16'h0000, "busy");
    wr(7'h03, 16'h0000, 1'b0);
    chk16({15'h0, dev_sleep}, 16'h0000, "sleep");
    busy <= 1'b1;
    cycles(4);
    chk16({15'h0, fault}, 16'h0000, "busy");
    // busy status is 0002, but with the pin off the host sees a floating line
    rd_chk(7'h02, 16'hfffd);
    chk16({15'h0, i_dcs_host_model.oe_seen}, 16'h0000, "oe");
    busy <= 1'b0;
    wr(7'h03, 16'h0a14, 1'b0);
    i_dcs_host_model.crc_on = 1'b1;
    chk16({15'h0, chk_on}, 16'h0001, "check");
    rd_chk(7'h03, 16'h0a94);
  endtask

  task automatic t_crc();
    wr(7'h0a, 16'h0005, 1'b1);
    chk16({15'h0, fault}, 16'h0001, "crc");
    rd_chk(7'h0a, 16'h0000);
    rd_chk(7'h02, 16'h0004);
    wr(7'h0e, 16'h0100, 1'b0);
    chk16({15'h0, fault}, 16'h0000, "clear");
    rd_chk(7'h02, 16'h0000);
  endtask

  task automatic t_heat();
    wr(7'h09, 16'h0000, 1'b0);
    chk16({15'h0, conv_sleep}, 16'h0000, "conv");
    rd_chk(7'h09, 16'hfffe);
    overheat <= 1'b1;
    cycles(6);
    chk16({15'h0, fault}, 16'h0001, "heat");
    chk16({15'h0, conv_sleep}, 16'h0001, "conv");
    rd_chk(7'h02, 16'h0001);
    overheat <= 1'b0;
    wr(7'h0e, 16'h0100, 1'b0);
    chk16({15'h0, fault}, 16'h0000, "clear");
    wr(7'h03, 16'h0014, 1'b0);
    overheat <= 1'b1;
    wr(7'h0a, 16'h0000, 1'b1);
    chk16({15'h0, fault}, 16'h0000, "route");
    chk16({15'h0, conv_sleep}, 16'h0001, "conv");
    rd_chk(7'h02, 16'h0005);
    overheat <= 1'b0;
    wr(7'h0e, 16'h0100, 1'b0);
    chk16({15'h0, conv_sleep}, 16'h0000, "conv");
  endtask

  task automatic t_range();
    logic [5:0] span [16];
    logic [7:0] exp;
    span = '{6'h05, 6'h0a, 6'h14, 6'h28, 6'h00, 6'h05, 6'h0a, 6'h14,
             6'h06, 6'h0c, 6'h18, 6'h00, 6'h00, 6'h06, 6'h0c, 6'h00};
    for (int c = 0; c < 16; c++)
    begin
      // the host writes only the twelve listed codes; a zero span marks the rest
      if (span[c] != 6'h00)
      begin
        wr(7'h0a, {12'h000, 4'(c)}, 1'b0);
        exp = {1'b1, c[2], span[c]};
        chk16({12'h000, rcode}, {12'h000, 4'(c)}, "code");
        chk16({8'h00, range}, {8'h00, exp}, "range");
      end
    end
    rd_chk(7'h0a, 16'h000e);
  endtask

  // ************************************************************
  // main sequence and watchdog
  // ************************************************************
  initial
  begin
    n_errors   = 0;
    num_checks = 0;
    reset_n    = 1'b0;
    overheat   = 1'b0;
    busy       = 1'b0;
    cycles(20);
    reset_n <= 1'b1;
    cycles(4);
    t_reset();
    t_general();
    t_serial();
    t_crc();
    t_heat();
    t_range();
    close_out();
  end

  initial
  begin
    cycles(90000);
    n_errors++;
    $display("ERROR %0t run did not finish", $time);
    close_out();
  end
endmodule
